/* File: verilog/ufl_pkg.sv */
// ufl_pkg: register map, field positions, reset values and trigger table selects
// for the uart fifo / line / modem control block.
// assumes a 32-bit apb slave with one aligned word per register.
package ufl_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_DATA    = 8'h00;
    localparam logic [7:0] OFS_ISR     = 8'h08;
    localparam logic [7:0] OFS_FIFO    = 8'h0c;
    localparam logic [7:0] OFS_FMT     = 8'h10;
    localparam logic [7:0] OFS_MDM     = 8'h14;
    localparam logic [7:0] OFS_EFR     = 8'h18;
    localparam logic [7:0] OFS_TBL     = 8'h1c;
    localparam logic [7:0] OFS_TXLVL   = 8'h20;
    localparam logic [7:0] OFS_RXLVL   = 8'h24;
    localparam logic [7:0] OFS_PTRIG   = 8'h28;
    localparam logic [7:0] OFS_STAT    = 8'h2c;
    localparam logic [7:0] OFS_DIVHI   = 8'h04;
    // ==========================================================
    // field positions
    localparam int FIFO_EN_B = 0;
    localparam int RX_RST_B = 1;
    localparam int TX_RST_B = 2;
    localparam int BLK_MODE_B = 3;
    localparam int EFR_ENH_B = 4;
    localparam int EFR_ARTS_B = 6;
    localparam int EFR_ACTS_B = 7;
    localparam int MDM_TR_B = 0;
    localparam int MDM_RTS_B = 1;
    localparam int MDM_FSEL_B = 2;
    localparam int ISR_FLOW_B = 5;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] LVL_ZERO = 7'h00;
    localparam logic [6:0] LVL_MAX = 7'h40;
    // ==========================================================
    // trigger table names; the tables, indexed by table and 2-bit select, are in ufl_ctrl
    typedef enum logic [1:0] {
        TBL_A = 2'b00,
        TBL_B = 2'b01,
        TBL_C = 2'b10,
        TBL_D = 2'b11
    } ufl_tbl_e;
    // decoded line format handed to the serial engine
    typedef struct packed {
        logic [3:0] data_bits;
        logic two_stop;
        logic half_stop;
        logic parity_en;
        logic parity_even;
        logic parity_forced;
        logic forced_value;
        logic break_on;
        logic divisor_sel;
    } ufl_fmt_s;
endpackage

/* File: verilog/ufl_ctrl.sv */
// ufl_ctrl: per-channel uart control logic behind an apb slave: fifo setup,
// character format, modem line drive, trigger tables and flow-change status.
// assumes the fifo and serial engines live outside and report tx/rx levels.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ufl_ctrl
    import ufl_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fifo engine side
    input wire logic [6:0] tx_level_i,
    input wire logic [6:0] rx_level_i,
    output logic rx_fifo_reset_o,
    output logic tx_fifo_reset_o,
    output logic [6:0] rx_trigger_o,
    output logic [6:0] tx_trigger_o,
    output logic tx_int_o,
    output logic fifo_enabled_o,
    // serial engine side
    input wire logic tx_serial_i,
    output logic tx_pin_o,
    output ufl_fmt_s fmt_o,
    // modem pins (active low names on the wire)
    input wire logic cts_n_i,
    output logic dtr_n_o,
    output logic rts_n_o,
    output logic flow_sel_o
);
    // ==========================================================
    // bus decode
    logic wr_en;
    logic rd_en;
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pwrite_i;
    assign pready_o = 1'b1; // zero-wait slave
    assign pslverr_o = 1'b0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // byte registers read back zero-extended to the bus width
    function automatic logic [31:0] zext8(input logic [7:0] b);
        zext8 = {24'h000000, b};
    endfunction

    // level fell from at-or-above the trigger to below it
    function automatic logic fell_below(input logic [6:0] prev, input logic [6:0] cur,
                                        input logic [6:0] trig);
        fell_below = (prev >= trig) && (cur < trig);
    endfunction

    // level reached empty from a non-empty count
    function automatic logic ran_empty(input logic [6:0] prev, input logic [6:0] cur);
        ran_empty = (prev != LVL_ZERO) && (cur == LVL_ZERO);
    endfunction

    // ==========================================================
    // control registers
    logic fifo_en_reg;
    logic blk_mode_reg;
    logic [1:0] rx_sel_reg;
    logic [1:0] tx_sel_reg;
    logic [7:0] fmt_reg;
    logic [7:0] mdm_reg;
    logic [7:0] efr_reg;
    logic [1:0] tbl_reg;
    logic [6:0] ptrig_rx_reg;
    logic [6:0] ptrig_tx_reg;
    logic [7:0] divhi_reg;
    logic rx_rst_reg;
    logic tx_rst_reg;
    logic flow_flag_reg;
    logic tx_int_reg;
    logic fifo_wr;
    logic enh;

    assign enh = efr_reg[EFR_ENH_B];
    assign fifo_wr = wr_en & hit(paddr_i, OFS_FIFO);

    // fifo setup, write only; bit 0 always taken, other bits ignored unless bit 0 is one
    // a write with bit 0 low only turns the fifos off; trigger and mode bits
    // keep their old values so software cannot half-program them
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fifo_en_reg <= 1'b0;
            blk_mode_reg <= 1'b0;
            rx_sel_reg <= 2'b00;
            tx_sel_reg <= 2'b00;
        end else if (fifo_wr) begin
            fifo_en_reg <= pwdata_i[FIFO_EN_B];
            if (pwdata_i[FIFO_EN_B]) begin
                blk_mode_reg <= pwdata_i[BLK_MODE_B]; // held only, drives nothing
                rx_sel_reg <= pwdata_i[7:6];
                if (enh) begin
                    tx_sel_reg <= pwdata_i[5:4];
                end
            end
        end
    end

    // self-clearing fifo reset strobes, one clock wide
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rx_rst_reg <= 1'b0;
            tx_rst_reg <= 1'b0;
        end else begin
            rx_rst_reg <= fifo_wr & pwdata_i[FIFO_EN_B] & pwdata_i[RX_RST_B];
            tx_rst_reg <= fifo_wr & pwdata_i[FIFO_EN_B] & pwdata_i[TX_RST_B];
        end
    end
    assign rx_fifo_reset_o = rx_rst_reg; // shift registers are outside and untouched
    assign tx_fifo_reset_o = tx_rst_reg;

    // read/write control registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fmt_reg <= RST_BYTE;
            mdm_reg <= RST_BYTE;
            efr_reg <= RST_BYTE;
            tbl_reg <= 2'b00;
            ptrig_rx_reg <= LVL_ZERO;
            ptrig_tx_reg <= LVL_ZERO;
            divhi_reg <= RST_BYTE;
        end else if (wr_en) begin
            if (hit(paddr_i, OFS_FMT)) begin
                fmt_reg <= pwdata_i[7:0];
            end
            if (hit(paddr_i, OFS_MDM)) begin
                mdm_reg <= pwdata_i[7:0];
            end
            if (hit(paddr_i, OFS_EFR)) begin
                efr_reg <= pwdata_i[7:0];
            end
            if (hit(paddr_i, OFS_TBL)) begin
                tbl_reg <= pwdata_i[7:6]; // latest write rules both sides
            end
            if (hit(paddr_i, OFS_PTRIG)) begin
                ptrig_rx_reg <= pwdata_i[6:0];
                ptrig_tx_reg <= pwdata_i[14:8];
            end
            if (hit(paddr_i, OFS_DIVHI) && fmt_reg[7]) begin
                divhi_reg <= pwdata_i[7:0];
            end
        end
    end

    // ==========================================================
    // trigger tables
    function automatic logic [6:0] rx_trig(input logic [1:0] t, input logic [1:0] s,
                                          input logic [6:0] p);
        logic [6:0] v;
        v = 7'h01;
        case (t)
            TBL_A: begin
                case (s)
                    2'b00: v = 7'h01;
                    2'b01: v = 7'h04;
                    2'b10: v = 7'h08;
                    default: v = 7'h0e;
                endcase
            end
            TBL_B: begin
                case (s)
                    2'b00: v = 7'h08;
                    2'b01: v = 7'h10;
                    2'b10: v = 7'h18;
                    default: v = 7'h1c;
                endcase
            end
            TBL_C: begin
                case (s)
                    2'b00: v = 7'h08;
                    2'b01: v = 7'h10;
                    2'b10: v = 7'h38;
                    default: v = 7'h3c;
                endcase
            end
            default: v = p;
        endcase
        rx_trig = v;
    endfunction

    function automatic logic [6:0] tx_trig(input logic [1:0] t, input logic [1:0] s,
                                          input logic [6:0] p);
        logic [6:0] v;
        v = 7'h01;
        case (t)
            TBL_A: v = 7'h01;
            TBL_B: begin
                case (s)
                    2'b00: v = 7'h10;
                    2'b01: v = 7'h08;
                    2'b10: v = 7'h18;
                    default: v = 7'h1e;
                endcase
            end
            TBL_C: begin
                case (s)
                    2'b00: v = 7'h08;
                    2'b01: v = 7'h10;
                    2'b10: v = 7'h20;
                    default: v = 7'h38;
                endcase
            end
            default: v = p;
        endcase
        tx_trig = v;
    endfunction

    // one shared table select for both directions
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rx_trigger_o <= 7'h01;
            tx_trigger_o <= 7'h01;
        end else begin
            rx_trigger_o <= rx_trig(tbl_reg, rx_sel_reg, ptrig_rx_reg);
            tx_trigger_o <= tx_trig(tbl_reg, tx_sel_reg, ptrig_tx_reg);
        end
    end

    // ==========================================================
    // transmit interrupt: falls below trigger, or empties after a
    // reload that never got above trigger
    logic [6:0] tx_level_d;
    logic above_reg;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tx_level_d <= LVL_ZERO;
            above_reg <= 1'b0;
            tx_int_reg <= 1'b0;
        end else begin
            tx_level_d <= tx_level_i;
            if (tx_level_i > tx_trigger_o) begin
                above_reg <= 1'b1;
            end else if (tx_level_i == LVL_ZERO) begin
                above_reg <= 1'b0;
            end
            if (fell_below(tx_level_d, tx_level_i, tx_trigger_o)) begin
                tx_int_reg <= 1'b1;
            end else if (ran_empty(tx_level_d, tx_level_i) && !above_reg) begin
                tx_int_reg <= 1'b1;
            end else if (rd_en && hit(paddr_i, OFS_ISR)) begin
                tx_int_reg <= 1'b0; // set above wins over this read clear
            end
        end
    end
    assign tx_int_o = tx_int_reg;

    // ==========================================================
    // flow pins: input synchroniser and rising-edge status
    logic cts_s1;
    logic cts_s2;
    logic cts_d;
    logic rts_d;
    logic flow_rise;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cts_s1 <= 1'b1;
            cts_s2 <= 1'b1;
            cts_d <= 1'b1;
            rts_d <= 1'b1;
        end else begin
            cts_s1 <= cts_n_i;
            cts_s2 <= cts_s1;
            cts_d <= cts_s2;
            rts_d <= rts_n_o;
        end
    end
    // the rts edge is taken from the output itself, so a write that drops the
    // modem bit shows up one clock later as a rising edge
    assign flow_rise = (cts_s2 & ~cts_d) | (rts_n_o & ~rts_d);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flow_flag_reg <= 1'b0;
        end else if (enh && flow_rise) begin
            flow_flag_reg <= 1'b1;
        end else if (rd_en && hit(paddr_i, OFS_STAT)) begin
            flow_flag_reg <= 1'b0; // cleared by modem status read
        end
    end

    // ==========================================================
    // line format and pins
    always_comb begin
        fmt_o.data_bits = 4'h5 + {2'b00, fmt_reg[1:0]};
        fmt_o.two_stop = fmt_reg[2] & (fmt_reg[1:0] != 2'b00);
        fmt_o.half_stop = fmt_reg[2] & (fmt_reg[1:0] == 2'b00);
        fmt_o.parity_en = fmt_reg[3];
        fmt_o.parity_even = fmt_reg[4];
        fmt_o.parity_forced = fmt_reg[3] & fmt_reg[5];
        fmt_o.forced_value = ~fmt_reg[4]; // mark when bit 4 low
        fmt_o.break_on = fmt_reg[6];
        fmt_o.divisor_sel = fmt_reg[7];
    end
    assign tx_pin_o = fmt_reg[6] ? 1'b0 : tx_serial_i; // break holds line low
    assign dtr_n_o = ~mdm_reg[MDM_TR_B];
    assign rts_n_o = ~mdm_reg[MDM_RTS_B];
    assign flow_sel_o = mdm_reg[MDM_FSEL_B]; // 1 = terminal-ready pair
    assign fifo_enabled_o = fifo_en_reg;

    // ==========================================================
    // read mux
    logic [7:0] isr_val;
    logic [3:0] isr_src;
    assign isr_src = tx_int_reg ? 4'h2 : 4'h1; // tx ready, else none pending
    assign isr_val = {{2{fifo_en_reg}}, flow_flag_reg & enh, 1'b0, isr_src};
    logic [31:0] rd_val;
    // prdata is loaded in the setup cycle so the access edge sees a settled
    // word; a read that clears a flag does so at the access edge, after capture
    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr_i)
            OFS_ISR: rd_val = zext8(isr_val);
            OFS_FMT: rd_val = zext8(fmt_reg);
            OFS_MDM: rd_val = zext8(mdm_reg);
            OFS_EFR: rd_val = zext8(efr_reg);
            OFS_TBL: rd_val = zext8({tbl_reg, 6'h00});
            OFS_TXLVL: rd_val = {25'h0000000, tx_level_i};
            OFS_RXLVL: rd_val = {25'h0000000, rx_level_i};
            OFS_PTRIG: rd_val = {17'h00000, ptrig_tx_reg, 1'b0, ptrig_rx_reg};
            OFS_STAT: rd_val = zext8({~cts_s2, 6'h00, flow_flag_reg});
            OFS_DIVHI: rd_val = fmt_reg[7] ? zext8(divhi_reg) : 32'h0000_0000;
            default: rd_val = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_val; // captured in setup, valid in access
        end
    end
endmodule
`default_nettype wire

/* File: testbench/ufl_ctrl_chk.sv */
// ufl_ctrl_chk: port-level assertions for the uart control block.
// assumes it is bound onto ufl_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ufl_ctrl_chk
    import ufl_pkg::*;
(
    // clock, reset and apb
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    // watched outputs and the serial feed
    input wire logic rx_fifo_reset_o,
    input wire logic tx_fifo_reset_o,
    input wire logic tx_int_o,
    input wire logic fifo_enabled_o,
    input wire logic tx_serial_i,
    input wire logic tx_pin_o,
    input wire ufl_fmt_s fmt_o,
    input wire logic dtr_n_o,
    input wire logic rts_n_o,
    input wire logic flow_sel_o
);
    // ==========================================================
    // write access strobe, all assertions on the one clock
    wire logic wr_any = psel_i && penable_i && pwrite_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    chk_rx_flush: assert property (
        wr_any && paddr_i == OFS_FIFO && pwdata_i[1:0] == 2'b11
        |=> rx_fifo_reset_o ##1 !rx_fifo_reset_o) else $error("rx flush pulse wrong");
    chk_tx_flush: assert property (
        wr_any && paddr_i == OFS_FIFO && pwdata_i[2:0] == 3'b101
        |=> tx_fifo_reset_o ##1 !tx_fifo_reset_o) else $error("tx flush pulse wrong");
    chk_fifo_gate: assert property (
        wr_any && paddr_i == OFS_FIFO && !pwdata_i[0]
        |=> !fifo_enabled_o && !rx_fifo_reset_o && !tx_fifo_reset_o) else $error("gate wrong");
    chk_isr_enable: assert property (
        psel_i && !penable_i && !pwrite_i && paddr_i == OFS_ISR
        |=> prdata_o[7:6] == {2{fifo_enabled_o}}) else $error("status 7:6 wrong");
    chk_break_hold: assert property (
        tx_pin_o == (tx_serial_i && !fmt_o.break_on)) else $error("break output wrong");
    chk_word_len: assert property (
        wr_any && paddr_i == OFS_FMT
        |=> fmt_o.data_bits == 4'd5 + {2'b00, $past(pwdata_i[1:0])}) else $error("length wrong");
    chk_fmt_bits: assert property (
        wr_any && paddr_i == OFS_FMT |=> fmt_o.parity_en == $past(pwdata_i[3])
        && fmt_o.divisor_sel == $past(pwdata_i[7])) else $error("format bits wrong");
    chk_modem_pins: assert property (
        wr_any && paddr_i == OFS_MDM |=> {flow_sel_o, rts_n_o, dtr_n_o}
        == ($past(pwdata_i[2:0]) ^ 3'b011)) else $error("modem pins wrong");
    chk_reset_idle: assert property (
        $fell(rst_i) |-> dtr_n_o && rts_n_o && !fifo_enabled_o && !tx_int_o)
        else $error("reset state wrong");
endmodule
bind ufl_ctrl ufl_ctrl_chk chk_u (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .rx_fifo_reset_o, .tx_fifo_reset_o, .tx_int_o,
    .fifo_enabled_o, .tx_serial_i, .tx_pin_o, .fmt_o, .dtr_n_o, .rts_n_o, .flow_sel_o);
`default_nettype wire

/* File: testbench/ufl_modem.sv */
// ufl_modem: far side of the line, a modem clear-to-send pin and a serial feed.
// assumes the bench commands the pin level; changes land after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module ufl_modem (
    // clock and commanded level
    input wire logic mclk_i,
    input wire logic cts_hi_i,
    // line side outputs
    output logic cts_n_o,
    output logic tx_serial_o
);
    // ==========================================================
    // serial data toggles every cycle so a stuck copy never passes
    always @(posedge mclk_i) begin
        cts_n_o <= cts_hi_i;
        tx_serial_o <= (tx_serial_o === 1'b1) ? 1'b0 : 1'b1;
    end
endmodule
`default_nettype wire

/* File: testbench/tb_uart_fifo_line_modem_control.sv */
// tb: apb register sequences with expected values for the uart control block.
// assumes ufl_ctrl answers with zero wait states and the modem model drives cts.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_line_modem_control;
    import ufl_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic cts_hi = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic [6:0] tx_level_i = 7'h00, rx_level_i = 7'h00, rx_trigger_o, tx_trigger_o;
    logic pready_o, pslverr_o, rx_fifo_reset_o, tx_fifo_reset_o, tx_int_o, fifo_enabled_o;
    logic tx_serial_i, tx_pin_o, cts_n_i, dtr_n_o, rts_n_o, flow_sel_o;
    ufl_fmt_s fmt_o;
    int err_count = 0, checks_done = 0;
    int rxt [12] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60};
    int txt [12] = '{1, 1, 1, 1, 16, 8, 24, 30, 8, 16, 32, 56};
    ufl_ctrl dut_u (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .tx_level_i, .rx_level_i, .rx_fifo_reset_o,
        .tx_fifo_reset_o, .rx_trigger_o, .tx_trigger_o, .tx_int_o, .fifo_enabled_o,
        .tx_serial_i, .tx_pin_o, .fmt_o, .cts_n_i, .dtr_n_o, .rts_n_o, .flow_sel_o);
    ufl_modem modem_u (.mclk_i, .cts_hi_i(cts_hi), .cts_n_o(cts_n_i), .tx_serial_o(tx_serial_i));
    // 50 ns clock
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    // one apb transfer: setup, then access held until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    // let n edges pass, then sample settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic complete_run();
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog, generous against the few hundred cycles the tests need
    initial begin
        #1_000_000;
        err_count++;
        complete_run();
    end
    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] q;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(OFS_FMT, 32'h0);
        rd(OFS_MDM, 32'h0);
        rd(OFS_ISR, 32'h01);
        rd(8'h30, 32'h0);
        for (int v = 0; v < 8; v++) begin
            wr(OFS_FMT, 32'(v));
            settle(0);
            check(32'(fmt_o.data_bits), 32'(5 + v[1:0]));
            check(32'({fmt_o.two_stop, fmt_o.half_stop}),
                32'({v[2] && v[1:0] != 0, v[2] && v[1:0] == 0}));
        end
        for (int p = 0; p < 4; p++) begin
            wr(OFS_FMT, 32'(8 | p << 4));
            settle(0);
            check(32'({fmt_o.parity_en, fmt_o.parity_forced,
                p[1] ? fmt_o.forced_value : fmt_o.parity_even}),
                32'({1'b1, p[1], p[1] ^ p[0]}));
        end
        wr(OFS_FMT, 32'h40);
        for (int k = 0; k < 3; k++) begin
            settle(1);
            check(32'(tx_pin_o), 32'h0);
        end
        wr(OFS_FMT, 32'h80);
        settle(0);
        check(32'(tx_pin_o), 32'(tx_serial_i));
        wr(OFS_DIVHI, 32'h5a);
        rd(OFS_DIVHI, 32'h5a);
        wr(OFS_FMT, 32'h0);
        rd(OFS_DIVHI, 32'h0);
        for (int m = 0; m < 8; m++) begin
            wr(OFS_MDM, 32'(m));
            settle(0);
            check(32'({flow_sel_o, rts_n_o, dtr_n_o}), 32'(m ^ 3));
            rd(OFS_MDM, 32'(m));
        end
        // fifo enable, flush pulses, gating and the inert block-mode bit
        wr(OFS_FIFO, 32'h01);
        rd(OFS_ISR, 32'hc1);
        wr(OFS_FIFO, 32'h07);
        settle(0);
        check(32'({rx_fifo_reset_o, tx_fifo_reset_o}), 32'h3);
        settle(1);
        check(32'({rx_fifo_reset_o, tx_fifo_reset_o}), 32'h0);
        wr(OFS_FIFO, 32'h0e);
        settle(0);
        check(32'({fifo_enabled_o, rx_fifo_reset_o, tx_fifo_reset_o}), 32'h0);
        rd(OFS_ISR, 32'h01);
        wr(OFS_FIFO, 32'h09);
        rd(OFS_ISR, 32'hc1);
        // tx trigger bits locked until the enhanced bit is set
        wr(OFS_TBL, 32'h40);
        wr(OFS_FIFO, 32'h31);
        settle(2);
        check(32'(tx_trigger_o), 32'd16);
        wr(OFS_EFR, 32'h10);
        wr(OFS_FIFO, 32'h31);
        settle(2);
        check(32'(tx_trigger_o), 32'd30);
        for (int i = 0; i < 12; i++) begin
            wr(OFS_TBL, 32'(i / 4 << 6));
            wr(OFS_FIFO, 32'((i % 4) * 8'h50 + 1));
            settle(2);
            check(32'({rx_trigger_o, tx_trigger_o}),
                32'({7'(rxt[i]), 7'(txt[i])}));
        end
        wr(OFS_TBL, 32'hc0);
        wr(OFS_PTRIG, 32'h2a15);
        settle(2);
        check(32'({rx_trigger_o, tx_trigger_o}), 32'({7'h15, 7'h2a}));
        // tx interrupt with trigger 8: crossing below, then empty after a low reload
        wr(OFS_TBL, 32'h80);
        wr(OFS_FIFO, 32'h01);
        tx_level_i <= 7'd10;
        repeat (3) @(posedge mclk_i);
        tx_level_i <= 7'd7;
        settle(3);
        check(32'(tx_int_o), 32'h1);
        rd(OFS_ISR, 32'hc2);
        tx_level_i <= 7'd0;
        settle(3);
        rd(OFS_ISR, 32'hc1);
        tx_level_i <= 7'd3;
        repeat (3) @(posedge mclk_i);
        tx_level_i <= 7'd0;
        settle(3);
        check(32'(tx_int_o), 32'h1);
        rd(OFS_ISR, 32'hc2);
        // flow-change flag from the cts pin and from the rts output
        cts_hi <= 1'b1;
        settle(6);
        rd(OFS_ISR, 32'he1);
        xfer(1'b0, OFS_STAT, 32'h0, q);
        rd(OFS_ISR, 32'hc1);
        wr(OFS_MDM, 32'h0);
        settle(3);
        rd(OFS_ISR, 32'he1);
        xfer(1'b0, OFS_STAT, 32'h0, q);
        wr(OFS_EFR, 32'h0);
        cts_hi <= 1'b0;
        repeat (6) @(posedge mclk_i);
        cts_hi <= 1'b1;
        settle(6);
        rd(OFS_ISR, 32'hc1);
        complete_run();
    end
endmodule
`default_nettype wire
